// *** src/aud_axil_regs.sv ***
// AXI4-Lite slave holding configuration and exposing data/status access.
// Assumes one write and one read in flight at most.
`timescale 1ns/1ps
`default_nettype none
module aud_axil_regs import aud_pkg::*; (
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [15:0]      cfgReg,
	output logic [15:0]      pscReg,
	output logic [15:0]      txWord,
	output logic             dataWr,
	output logic             dataRd,
	output logic             stsRd,
	input  wire logic [15:0] rxWord,
	input  wire logic [15:0] stsWord
);
	logic        awHeld_r, wHeld_r, bvalid_r, rvalid_r;
	logic [3:0]  awAddr_r;
	logic [15:0] wData_r, cfg_r, psc_r, rdWord;
	logic [1:0]  wStrb_r, bresp_r, rresp_r;
	logic [31:0] rdata_r;
	logic        doWr, rdTake;

	function automatic logic [15:0] mergeLanes(logic [15:0] o, logic [15:0] n, logic [1:0] s);
		return {s[1] ? n[15:8] : o[15:8], s[0] ? n[7:0] : o[7:0]};
	endfunction

	assign awready = !awHeld_r && !bvalid_r;
	assign wready  = !wHeld_r && !bvalid_r;
	assign doWr    = awHeld_r && wHeld_r;
	assign dataWr  = doWr && awAddr_r == ADDR_DATA;
	assign arready = !rvalid_r;
	assign rdTake  = arvalid && !rvalid_r;
	assign dataRd  = rdTake && araddr == ADDR_DATA;
	assign stsRd   = rdTake && araddr == ADDR_STS;
	assign rdWord  = (araddr == ADDR_CFG) ? cfg_r :
	                 (araddr == ADDR_PSC) ? psc_r :
	                 (araddr == ADDR_DATA) ? rxWord :
	                 (araddr == ADDR_STS) ? stsWord : WORD_ZERO;
	assign txWord  = wData_r;
	assign cfgReg  = cfg_r;
	assign pscReg  = psc_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign rvalid  = rvalid_r;
	assign rresp   = rresp_r;
	assign rdata   = rdata_r;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			awHeld_r <= 1'b0;
			wHeld_r  <= 1'b0;
			awAddr_r <= '0;
			wData_r  <= WORD_ZERO;
			wStrb_r  <= '0;
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OK;
			cfg_r    <= CFG_RST;
			psc_r    <= PSC_RST;
		end else begin
			if (awvalid && awready) begin
				awHeld_r <= 1'b1;
				awAddr_r <= awaddr;
			end else if (doWr)
				awHeld_r <= 1'b0;
			if (wvalid && wready) begin
				wHeld_r <= 1'b1;
				wData_r <= mergeLanes(WORD_ZERO, wdata[15:0], wstrb[1:0]);
				wStrb_r <= wstrb[1:0];
			end else if (doWr)
				wHeld_r <= 1'b0;
			if (doWr) begin
				bvalid_r <= 1'b1;
				bresp_r  <= (awAddr_r[1:0] == LANE_ZERO) ? RESP_OK : RESP_ERR;
			end else if (bready)
				bvalid_r <= 1'b0;
			if (doWr && awAddr_r == ADDR_CFG)
				cfg_r <= mergeLanes(cfg_r, wData_r, wStrb_r);
			if (doWr && awAddr_r == ADDR_PSC)
				psc_r <= mergeLanes(psc_r, wData_r, wStrb_r);
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rvalid_r <= 1'b0;
			rdata_r  <= '0;
			rresp_r  <= RESP_OK;
		end else if (rdTake) begin
			rvalid_r <= 1'b1;
			rdata_r  <= {WORD_ZERO, rdWord};
			rresp_r  <= (araddr[1:0] == LANE_ZERO) ? RESP_OK : RESP_ERR;
		end else if (rready)
			rvalid_r <= 1'b0;
	end
endmodule
`default_nettype wire

// *** src/aud_clk_div.sv ***
// Programmable bit clock and master clock divider.
// Assumes run is low whenever the block is not master.
`timescale 1ns/1ps
`default_nettype none
module aud_clk_div import aud_pkg::*; (
	input  wire logic       mclk,
	input  wire logic       arst_n,
	input  wire logic       run,
	input  wire logic [7:0] prescale,
	input  wire logic       oddDiv,
	input  wire logic       mckEn,
	output logic            bckLevel,
	output logic            bckRise,
	output logic            bckFall,
	output logic            mckLevel
);
	logic [8:0] cnt_r;
	logic       bck_r;
	logic       mck_r;
	logic [7:0] divEff;
	logic [8:0] halfLast;
	logic       wrap;

	// Zero prescale would stall the clock, so it runs as one
	assign divEff   = (prescale < DIV_MIN) ? DIV_MIN : prescale;
	// Odd division stretches the high phase by one cycle
	assign halfLast = {1'b0, divEff} + {8'h00, bck_r & oddDiv} - 9'h001;
	assign wrap     = run && cnt_r == halfLast;
	assign bckRise  = wrap && !bck_r;
	assign bckFall  = wrap && bck_r;
	assign bckLevel = bck_r;
	assign mckLevel = mck_r;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= '0;
			bck_r <= 1'b0;
			mck_r <= 1'b0;
		end else begin
			cnt_r <= (!run || wrap) ? '0 : cnt_r + 9'h001;
			bck_r <= run ? (bck_r ^ wrap) : 1'b0;
			mck_r <= mckEn ? !mck_r : 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** src/aud_pkg.sv ***
// Shared constants, types and framing helpers of the audio serial block.
// Assumes 16-bit data halves and a 16-bit register window on AXI4-Lite.
package aud_pkg;
	localparam logic [3:0]  ADDR_CFG        = 4'h0;
	localparam logic [3:0]  ADDR_PSC        = 4'h4;
	localparam logic [3:0]  ADDR_DATA       = 4'h8;
	localparam logic [3:0]  ADDR_STS        = 4'hc;
	localparam logic [1:0]  LANE_ZERO       = 2'h0;
	localparam logic [1:0]  RESP_OK         = 2'h0;
	localparam logic [1:0]  RESP_ERR        = 2'h2;
	localparam logic [15:0] CFG_RST         = 16'h0000;
	localparam logic [15:0] PSC_RST         = 16'h0002;
	localparam logic [15:0] WORD_ZERO       = 16'h0000;
	localparam logic [15:0] MASK_ALL        = 16'hffff;
	localparam logic [15:0] MASK_HI         = 16'hff00;
	localparam logic [15:0] MASK_LO         = 16'h00ff;
	localparam int          CFG_EN          = 0;
	localparam int          CFG_MASTER      = 1;
	localparam int          CFG_TX          = 2;
	localparam int          CFG_STD         = 3;
	localparam int          CFG_PCMLONG     = 5;
	localparam int          CFG_DLEN        = 6;
	localparam int          CFG_CH32        = 8;
	localparam int          CFG_TXEIE       = 9;
	localparam int          CFG_RXNEIE      = 10;
	localparam int          PSC_DIV         = 0;
	localparam int          PSC_ODD         = 8;
	localparam int          PSC_MCKEN       = 9;
	localparam int          STS_TXE         = 0;
	localparam int          STS_RXNE        = 1;
	localparam int          STS_UDR         = 2;
	localparam int          STS_OVR         = 3;
	localparam int          STS_CHSIDE      = 4;
	localparam int          STS_BUSY        = 5;
	localparam logic [4:0]  LAST16          = 5'h0f;
	localparam logic [4:0]  LAST32          = 5'h1f;
	localparam logic [3:0]  HALF_LAST       = 4'hf;
	localparam logic [4:0]  LONG_SYNC_RUN   = 5'h0d;
	localparam logic [4:0]  SHORT_SYNC_RUN  = 5'h01;
	localparam logic [7:0]  DIV_MIN         = 8'h01;

	typedef enum logic [1:0] {STD_I2S, STD_MSB, STD_LSB, STD_PCM} aud_std_t;
	typedef enum logic [1:0] {DLEN_16, DLEN_24, DLEN_32, DLEN_RSV} aud_dlen_t;
	typedef enum logic [1:0] {LNK_IDLE, LNK_HUNT, LNK_ARMED, LNK_LIVE} aud_link_t;

	// Last bit index of one channel slot
	function automatic logic [4:0] slotLast(aud_dlen_t d, logic c32);
		return (d == DLEN_16 && !c32) ? LAST16 : LAST32;
	endfunction

	// Whether a 16-bit half of the slot carries buffer data or forced zeros
	function automatic logic halfLive(aud_std_t s, aud_dlen_t d, logic c32, logic h);
		if (d != DLEN_16 || !c32)
			return 1'b1;
		return (s == STD_LSB) ? h : !h;
	endfunction

	// Bits of a half that belong to a 24-bit sample
	function automatic logic [15:0] halfMask(aud_std_t s, aud_dlen_t d, logic h);
		if (d != DLEN_24)
			return MASK_ALL;
		if (s == STD_LSB)
			return h ? MASK_ALL : MASK_LO;
		return h ? MASK_HI : MASK_ALL;
	endfunction
endpackage

// *** src/aud_serial_top.sv ***
// Audio serial framing engine: I2S, MSB, LSB and PCM framing on one data line.
// Assumes pins are synchronous to mclk and the partner honours its framing.
//
// What this block does
// - Uses data, word select, bit clock, master clock pins; bit clock out as master.
// - Master clock pin toggles only in master mode with its enable bit set.
// - Standard field picks I2S, MSB, LSB or PCM; all but PCM are stereo.
// - Supports 16-in-16, 16-in-32, 24-in-32 and 32-bit formats.
// - Data buffers are 16 bits; 24 and 32-bit samples take two accesses.
// - Most significant bit of each sample goes first.
// - Left channel sample always precedes right channel sample.
// - I2S mode: word select and data change on falling, sampled on rising.
// - I2S 24-bit: first half is top 16 bits, second half's low byte zero.
// - I2S/MSB 16-in-32: one access, trailing 16 bits forced to zero.
// - Transmit empty flag rises when a word may be written; can interrupt.
// - Receive flag sets per arriving half; can interrupt.
// - MSB mode: word select changes with the first data bit.
// - MSB and LSB modes: change data on falling, sample on rising edges.
// - LSB mode right-justifies data when the slot is longer.
// - LSB 24-bit: first half carries top byte low, upper byte zero.
// - LSB 16-in-32: one access, leading 16 bits forced to zero.
// - PCM has no channel select; a bit picks short or long sync.
// - PCM master long sync holds word select for 13 bit periods.
// - PCM master short sync drives word select for one bit period.
// - Bit clock rate is bits per channel times channels times sample rate.
// - Missing transmit word at a slot start sets the underrun flag.
// - Receive word arriving before the last is read sets overrun.
// - First word written after enabling goes out as left channel.
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module aud_serial_top import aud_pkg::*; (
	input  wire logic        mclk,
	input  wire logic        arst_n,
	input  wire logic [3:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [3:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	input  wire logic        sdIn,
	output logic             sdOut,
	output logic             sdOutEn,
	input  wire logic        wsIn,
	output logic             wsOut,
	output logic             wsOutEn,
	input  wire logic        bckIn,
	output logic             bckOut,
	output logic             bckOutEn,
	output logic             mckOut,
	output logic             irqReq
);
	logic [15:0] cfgReg, pscReg, txWord, stsWord;
	logic [15:0] txBuf_r, rxBuf_r, txShift_r, rxShift_r;
	logic        dataWr, dataRd, stsRd;
	logic        divRise, divFall, divBck, divMck;
	aud_link_t   link_r, link_nxt;
	aud_std_t    std;
	aud_dlen_t   dlen;
	logic [4:0]  bitCnt_r, wsRun_r;
	logic        ch_r, txFull_r, rxne_r, udr_r, ovr_r, chSide_r;
	logic        wsOut_r, bckD_r, wsD_r;

	aud_axil_regs u_regs (
		.mclk    (mclk),
		.arst_n  (arst_n),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.cfgReg  (cfgReg),
		.pscReg  (pscReg),
		.txWord  (txWord),
		.dataWr  (dataWr),
		.dataRd  (dataRd),
		.stsRd   (stsRd),
		.rxWord  (rxBuf_r),
		.stsWord (stsWord)
	);

	// Configuration decode
	wire logic en      = cfgReg[CFG_EN];
	wire logic master  = cfgReg[CFG_MASTER];
	wire logic txMode  = cfgReg[CFG_TX];
	wire logic pcmLong = cfgReg[CFG_PCMLONG];
	wire logic ch32    = cfgReg[CFG_CH32];
	assign std  = aud_std_t'(cfgReg[CFG_STD +: 2]);
	assign dlen = aud_dlen_t'(cfgReg[CFG_DLEN +: 2]);
	wire logic running = link_r == LNK_ARMED || link_r == LNK_LIVE;

	aud_clk_div u_div (
		.mclk     (mclk),
		.arst_n   (arst_n),
		.run      (running && master),
		.prescale (pscReg[PSC_DIV +: 8]),
		.oddDiv   (pscReg[PSC_ODD]),
		.mckEn    (en && master && pscReg[PSC_MCKEN]),
		.bckLevel (divBck),
		.bckRise  (divRise),
		.bckFall  (divFall),
		.mckLevel (divMck)
	);

	// Bit clock edges: own divider as master, partner's pin as slave
	wire logic bckRise = master ? divRise : (bckIn && !bckD_r);
	wire logic bckFall = master ? divFall : (!bckIn && bckD_r);
	wire logic [4:0] lastBit = slotLast(dlen, ch32);

	// Slave alignment: I2S and PCM short sync lead the data by one bit
	wire logic rightWs = std == STD_I2S || std == STD_PCM;
	wire logic earlyWs = std == STD_I2S || (std == STD_PCM && !pcmLong);
	wire logic syncHit = bckRise && wsIn != wsD_r && wsIn == rightWs;

	// Slot counter advance; PCM stays on one channel
	wire logic       atLast = bitCnt_r == lastBit;
	wire logic [4:0] nxtCnt = atLast ? '0 : bitCnt_r + 5'h01;
	wire logic       nxtCh  = (atLast && std != STD_PCM) ? !ch_r : ch_r;
	// Framing only goes live at a left slot, so the first word is left
	wire logic goLive   = bckFall && link_r == LNK_ARMED && nxtCnt == '0 && !nxtCh;
	wire logic slotFall = bckFall && (link_r == LNK_LIVE || goLive);

	// Transmit half loading at the start of each 16-bit half
	wire logic        halfStart = nxtCnt[3:0] == '0;
	wire logic        txLive    = halfLive(std, dlen, ch32, nxtCnt[4]);
	wire logic        txSlot    = slotFall && txMode && halfStart;
	wire logic        txConsume = txSlot && txLive && txFull_r;
	wire logic        txUnder   = txSlot && txLive && !txFull_r;
	wire logic [15:0] txLoad    = txBuf_r & halfMask(std, dlen, nxtCnt[4]);
	wire logic        txLoadMsb = txLoad[15];

	// Receive delivery at the end of each live half
	wire logic        rxHalfEnd = bitCnt_r[3:0] == HALF_LAST;
	wire logic        rxLive    = halfLive(std, dlen, ch32, bitCnt_r[4]);
	wire logic        rxDeliver = bckRise && link_r == LNK_LIVE && !txMode && rxHalfEnd && rxLive;
	wire logic [15:0] rxWord    = {rxShift_r[14:0], sdIn} & halfMask(std, dlen, bitCnt_r[4]);
	// A read in the same cycle frees the buffer, so that arrival is kept
	wire logic        ovrHit    = rxDeliver && rxne_r && !dataRd;
	wire logic        rxAccept  = rxDeliver && !ovrHit;
	wire logic        txEmpty   = en && txMode && !txFull_r;

	// Master word select for the bit being started
	wire logic wsI2s = (nxtCnt == lastBit) ? !nxtCh : nxtCh;
	wire logic wsPcm = pcmLong ? (nxtCnt < LONG_SYNC_RUN) : (nxtCnt == lastBit);
	wire logic wsNxt = (std == STD_PCM) ? wsPcm : (std == STD_I2S) ? wsI2s : !nxtCh;

	always_comb begin
		link_nxt = link_r;
		unique case (link_r)
			LNK_IDLE: begin
				if (en && !master)
					link_nxt = LNK_HUNT;
				else if (en && (!txMode || txFull_r))
					link_nxt = LNK_ARMED;
			end
			LNK_HUNT: begin
				if (syncHit)
					link_nxt = LNK_ARMED;
			end
			LNK_ARMED: begin
				if (goLive)
					link_nxt = LNK_LIVE;
			end
			LNK_LIVE: link_nxt = LNK_LIVE;
		endcase
		if (!en)
			link_nxt = LNK_IDLE;
	end

	always_comb begin
		stsWord             = WORD_ZERO;
		stsWord[STS_TXE]    = txEmpty;
		stsWord[STS_RXNE]   = rxne_r;
		stsWord[STS_UDR]    = udr_r;
		stsWord[STS_OVR]    = ovr_r;
		stsWord[STS_CHSIDE] = chSide_r;
		stsWord[STS_BUSY]   = running;
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			link_r   <= LNK_IDLE;
			bitCnt_r <= '0;
			ch_r     <= 1'b0;
		end else begin
			link_r <= link_nxt;
			if (link_r == LNK_IDLE) begin
				bitCnt_r <= lastBit;
				ch_r     <= std != STD_PCM;
			end else if (link_r == LNK_HUNT && syncHit) begin
				bitCnt_r <= earlyWs ? lastBit : '0;
				ch_r     <= !earlyWs && std != STD_PCM;
			end else if (running && bckFall) begin
				bitCnt_r <= nxtCnt;
				ch_r     <= nxtCh;
			end
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			txBuf_r   <= WORD_ZERO;
			txFull_r  <= 1'b0;
			txShift_r <= WORD_ZERO;
		end else begin
			if (dataWr)
				txBuf_r <= txWord;
			txFull_r <= dataWr || (txFull_r && !txConsume);
			if (slotFall && txMode)
				txShift_r <= halfStart ? (txConsume ? txLoad : WORD_ZERO) : {txShift_r[14:0], 1'b0};
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rxShift_r <= WORD_ZERO;
			rxBuf_r   <= WORD_ZERO;
			rxne_r    <= 1'b0;
			udr_r     <= 1'b0;
			ovr_r     <= 1'b0;
			chSide_r  <= 1'b0;
		end else begin
			if (bckRise && running)
				rxShift_r <= {rxShift_r[14:0], sdIn};
			if (rxAccept)
				rxBuf_r <= rxWord;
			rxne_r <= rxAccept || (rxne_r && !dataRd);
			udr_r  <= txUnder || (udr_r && !stsRd);
			ovr_r  <= ovrHit || (ovr_r && !stsRd);
			if (txConsume)
				chSide_r <= nxtCh;
			else if (rxDeliver)
				chSide_r <= ch_r;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wsOut_r <= 1'b0;
			bckD_r  <= 1'b0;
			wsD_r   <= 1'b0;
			wsRun_r <= '0;
		end else begin
			bckD_r <= bckIn;
			if (bckRise)
				wsD_r <= wsIn;
			// Idle framing parks word select low so a new mode never starts on a stale pulse
			if (!running) begin
				wsOut_r <= 1'b0;
				wsRun_r <= '0;
			end else if (bckFall) begin
				if (master)
					wsOut_r <= wsNxt;
				wsRun_r <= wsOut_r ? wsRun_r + 5'h01 : '0;
			end
		end
	end

	assign sdOut    = txShift_r[15];
	assign sdOutEn  = en && txMode;
	assign wsOut    = wsOut_r;
	assign wsOutEn  = en && master;
	assign bckOut   = divBck;
	assign bckOutEn = en && master;
	assign mckOut   = divMck;
	assign irqReq   = (txEmpty && cfgReg[CFG_TXEIE]) || (rxne_r && cfgReg[CFG_RXNEIE]);

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!arst_n);

	sequence longSyncEnd;
		$fell(wsOut_r) && master && std == STD_PCM && pcmLong;
	endsequence
	sequence shortSyncEnd;
		$fell(wsOut_r) && master && std == STD_PCM && !pcmLong;
	endsequence

	long_sync_len_a: assert property (longSyncEnd |-> wsRun_r == LONG_SYNC_RUN)
		else $error("long sync pulse length wrong");
	short_sync_len_a: assert property (shortSyncEnd |-> wsRun_r == SHORT_SYNC_RUN)
		else $error("short sync pulse length wrong");
	tx_empty_clr_a: assert property (dataWr |=> !txEmpty)
		else $error("transmit empty still set after write");
	rx_flag_set_a: assert property (rxAccept |=> rxne_r && rxBuf_r == $past(rxWord))
		else $error("received half not stored");
	overrun_set_a: assert property (ovrHit |=> ovr_r && $stable(rxBuf_r))
		else $error("overrun not flagged or data replaced");
	underrun_set_a: assert property (txUnder |=> udr_r)
		else $error("underrun not flagged");
	msb_first_a: assert property (txConsume |=> sdOut == $past(txLoadMsb))
		else $error("first bit is not the sample msb");
	zero_pad_a: assert property (txSlot && !txLive |=> txShift_r == WORD_ZERO)
		else $error("padding half not forced to zero");
	left_first_a: assert property ($rose(link_r == LNK_LIVE) |-> !ch_r && bitCnt_r == '0)
		else $error("framing went live off a left slot");
	ws_on_fall_a: assert property (master && $changed(wsOut_r) |-> $past(bckFall))
		else $error("word select moved off a falling edge");
endmodule
`default_nettype wire

// *** tb/aud_codec_model.sv ***
// Listening codec model: samples data and word select at each bit clock rise.
// Assumes master mode; its data line is a plain pull-up, so it reads all ones.
`timescale 1ns/1ps
`default_nettype none
module aud_codec_model (
	input  wire logic       mclk,
	input  wire logic       clr,
	input  wire logic       bckOut,
	input  wire logic       wsOut,
	input  wire logic       sdOut,
	output logic            sdIn,
	output logic [15:0]     capSd,
	output logic [15:0]     capWs,
	output logic [7:0]      nRise,
	output logic [4:0]      wsMax
);
	logic       bckQ_r;
	logic [4:0] run_r;
	assign sdIn = 1'b1;
	always_ff @(posedge mclk) begin
		bckQ_r <= bckOut;
		if (clr) begin
			{capSd, capWs, nRise, wsMax, run_r} <= '0;
		end else if (bckOut && !bckQ_r) begin
			capSd <= {capSd[14:0], sdOut};
			capWs <= {capWs[14:0], wsOut};
			nRise <= nRise + 8'h01;
			run_r <= wsOut ? run_r + 5'h01 : 5'h00;
			if (wsOut && run_r + 5'h01 > wsMax) begin
				wsMax <= run_r + 5'h01;
			end
		end
	end
endmodule
`default_nettype wire

// *** tb/aud_serial_top_tb_top.sv ***
// Bench for the audio serial block: AXI4-Lite tasks and framing tests.
// Assumes the codec model listens in master mode and ties its data line high.
`timescale 1ns/1ps
`default_nettype none
module aud_serial_top_tb_top import aud_pkg::*;;
	logic        mclk, arst_n, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, sdIn, sdOut, sdOutEn, wsIn;
	logic        wsOut, wsOutEn, bckIn, bckOut, bckOutEn, mckOut, irqReq, clr;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, rd;
	logic [1:0]  bresp, rresp, rs;
	logic [15:0] capSd, capWs;
	logic [7:0]  nRise;
	logic [4:0]  wsMax;
	int          n_fail, total_checks, mckHi, i;
	time         t0;
	aud_serial_top uut (.*);
	aud_codec_model codec (.*);
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	always @(posedge mclk) if (mckOut) mckHi++;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		logic ta, tw, tb;
		int n;
		@(posedge mclk);
		n = 0;
		tb = 1'b0;
		awaddr  <= a;
		wdata   <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		while (!tb && n < 99) begin
			@(negedge mclk);
			ta = awvalid && awready;
			tw = wvalid && wready;
			tb = bvalid;
			rs = bresp;
			n++;
			@(posedge mclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		bready <= 1'b0;
	endtask
	task automatic rdr(input logic [3:0] a);
		logic ta, tv;
		int n;
		@(posedge mclk);
		n = 0;
		tv = 1'b0;
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		while (!tv && n < 99) begin
			@(negedge mclk);
			ta = arvalid && arready;
			tv = rvalid;
			rd = rdata;
			rs = rresp;
			n++;
			@(posedge mclk);
			if (ta) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask
	task automatic waitRise(input logic [7:0] k);
		int n;
		n = 0;
		while (nRise !== k && n < 9999) begin
			@(negedge mclk);
			n++;
		end
	endtask
	task automatic test_done;
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// The whole run needs well under 2000 cycles; ten times that means a hang
	initial begin
		repeat (20000) @(posedge mclk);
		n_fail++;
		test_done;
	end
	initial begin
		{arst_n, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wsIn, bckIn} = '0;
		wstrb = 4'hf;
		clr = 1'b1;
		n_fail = 0;
		total_checks = 0;
		mckHi = 0;
		repeat (20) @(posedge mclk);
		arst_n <= 1'b1;
		rdr(ADDR_CFG);
		chk(rd, 32'h0000_0000);
		rdr(ADDR_PSC);
		chk(rd, 32'h0000_0002);
		rdr(4'h2);
		chk(rs, RESP_ERR);
		$display("test reset done");
		wr(ADDR_CFG, 16'h0207);
		clr <= 1'b0;
		wr(ADDR_DATA, 16'ha5c3);
		// Rise 1 comes before the first fall, so the word is loaded only after it
		waitRise(2);
		chk(irqReq, 1'b1);
		wr(ADDR_DATA, 16'h3c5a);
		waitRise(17);
		t0 = $time;
		chk(capSd, 16'ha5c3);
		chk(capWs, 16'h0001);
		chk(irqReq, 1'b0);
		waitRise(33);
		chk(capSd, 16'h3c5a);
		chk(capWs, 16'hfffe);
		chk(32'($time - t0), 32'h0000_0500);
		waitRise(34);
		rdr(ADDR_STS);
		chk(rd[2:0], 3'b101);
		wr(ADDR_CFG, 16'h0007);
		chk(irqReq, 1'b0);
		wr(ADDR_CFG, 16'h0000);
		$display("test i2s done");
		for (i = 0; i < 2; i++) begin
			wr(ADDR_PSC, i ? 16'h0202 : 16'h0002);
			clr <= 1'b1;
			mckHi = 0;
			wr(ADDR_CFG, i ? 16'h001b : 16'h003b);
			clr <= 1'b0;
			waitRise(40);
			chk(wsMax, i ? 5'h01 : 5'h0d);
			chk(mckHi != 0, i[0]);
			rdr(ADDR_STS);
			chk(rd[3:1], 3'b101);
			rdr(ADDR_DATA);
			chk(rd, 32'h0000_ffff);
			wr(ADDR_CFG, 16'h0000);
		end
		$display("test pcm done");
		test_done;
	end
endmodule
`default_nettype wire
